// ===== src/isadec_params.svh
// Constants for the ISA slave port and logical device decoder
// Operation
// - A cycle is programmed I/O only with a valid enabled address, all DMA acknowledges idle and AEN low.
// - Programmed I/O and DMA data paths to the host are eight bits wide.
// - During a decoded read the selected register data is driven while the read strobe is held.
// - The host puts data on the bus and pulses the write strobe; the data is captured on its rising edge.
// - The codec and control functions compare 12 address bits; all other functions compare 10.
// - A 10-bit function matches only with A10 and A11 both zero, so it never aliases in 12-bit space.
// - With 16-bit decode every match also needs SA12 to SA15 all zero.
// - Selecting 16-bit decode turns the CDROM function off, since the upper address shares its pins.
// - After power-up no address is answered and every logical device is inactive until software activates it.
// - An active logical device answers only its assigned address range, interrupt and DMA channel.
// - Five logical devices exist: 0 codec with synthesizer and legacy audio, 1 game, 2 control, 3 MIDI, 4 CDROM.
// - The CDROM device decodes up to eight I/O locations with one interrupt and one DMA channel.
// - While a DMA acknowledge is active the address is ignored and data goes to the DMA function.
`ifndef ISADEC_PARAMS_SVH
`define ISADEC_PARAMS_SVH

`define ISADEC_DW       8
`define ISADEC_AW       16
`define ISADEC_NFN      7
`define ISADEC_NLD      5
`define ISADEC_NDMA     3
`define ISADEC_NIRQ     6
`define ISADEC_SYNC     3
// Function indices
`define ISADEC_FN_CODEC 0
`define ISADEC_FN_SYNTH 1
`define ISADEC_FN_LEG   2
`define ISADEC_FN_GAME  3
`define ISADEC_FN_CTRL  4
`define ISADEC_FN_MIDI  5
`define ISADEC_FN_CDROM 6
// Logical device numbers
`define ISADEC_LD_AUDIO 0
`define ISADEC_LD_GAME  1
`define ISADEC_LD_CTRL  2
`define ISADEC_LD_MIDI  3
`define ISADEC_LD_CDROM 4
// Window sizes as log2 of location count
`define ISADEC_SPAN_CODEC 3
`define ISADEC_SPAN_SYNTH 2
`define ISADEC_SPAN_LEG   4
`define ISADEC_SPAN_GAME  0
`define ISADEC_SPAN_CTRL  3
`define ISADEC_SPAN_MIDI  1
`define ISADEC_SPAN_CDROM 3
// Address fields
`define ISADEC_A12_MSB  11
`define ISADEC_A10_MSB  9
`define ISADEC_ALIAS_LSB 10
`define ISADEC_HI_LSB   12
`define ISADEC_CFGW     12
`define ISADEC_IRQSELW  3
`define ISADEC_DMASELW  2

`endif

// ===== src/isadec_pkg.sv
// Types shared by the ISA slave port and decoder
`include "isadec_params.svh"
package isadec_pkg;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_RD   = 3'b010,
    ST_WR   = 3'b100
  } isadec_state_type;

  typedef struct packed {
    isadec_state_type                          st;
    logic [`ISADEC_SYNC-1:0]                   ior_s;
    logic [`ISADEC_SYNC-1:0]                   iow_s;
    logic [`ISADEC_SYNC-1:0]                   aen_s;
    logic [`ISADEC_SYNC-1:0][`ISADEC_NDMA-1:0] dack_s;
    logic [`ISADEC_SYNC-1:0][`ISADEC_AW-1:0]   sa_s;
    logic [`ISADEC_SYNC-1:0][`ISADEC_DW-1:0]   d_s;
    logic                                      ior_l;
    logic                                      iow_l;
    logic                                      aen_l;
    logic [`ISADEC_NDMA-1:0]                   dack_l;
    logic [`ISADEC_AW-1:0]                     sa_l;
    logic [`ISADEC_DW-1:0]                     d_l;
    logic [`ISADEC_NFN-1:0]                    fsel;
    logic [`ISADEC_NLD-1:0]                    dsel;
    logic                                      wr_pulse;
    logic [`ISADEC_DW-1:0]                     wr_data;
    logic [`ISADEC_DW-1:0]                     dout;
    logic                                      oe_n;
    logic [`ISADEC_NIRQ-1:0]                   irq;
    logic [`ISADEC_NDMA-1:0]                   drq;
  } isadec_regs_type;
endpackage

// ===== src/isadec_match.sv
// Address window comparator for one function
`timescale 1ns/10ps
`include "isadec_params.svh"
module isadec_match #(
  parameter int SPAN  = 3,
  parameter bit USE12 = 1'b0
) (
  input  wire logic [`ISADEC_AW-1:0]   addr,
  input  wire logic [`ISADEC_CFGW-1:0] base,
  input  wire logic                    en,
  input  wire logic                    dec16,
  output logic                         hit
);
  logic [`ISADEC_CFGW-1:0] diff;
  logic                    low_ok;
  logic                    hi_ok;

  // Window compare above the span bits
  assign diff = (addr[`ISADEC_A12_MSB:0] ^ base) >> SPAN;
  assign low_ok = USE12 ? (diff == '0)
                : ((diff[`ISADEC_A10_MSB-SPAN:0] == '0)
                && (addr[`ISADEC_A12_MSB:`ISADEC_ALIAS_LSB] == '0));
  assign hi_ok = !dec16 || (addr[`ISADEC_AW-1:`ISADEC_HI_LSB] == '0);
  assign hit = en && low_ok && hi_ok;
endmodule // isadec_match

// ===== src/isadec_top.sv
// ISA 8-bit slave port with logical device address decode
`timescale 1ns/10ps
`include "isadec_params.svh"
module isadec_top (
  input  wire logic                                        clk,
  input  wire logic                                        sys_rst,
  input  wire logic [`ISADEC_AW-1:0]                       sa,
  input  wire logic                                        aen,
  input  wire logic                                        ior_n,
  input  wire logic                                        iow_n,
  input  wire logic [`ISADEC_NDMA-1:0]                     dack_n,
  input  wire logic [`ISADEC_DW-1:0]                       data_in,
  output logic [`ISADEC_DW-1:0]                            data_out,
  output logic                                             data_oe_n,
  output logic [`ISADEC_NIRQ-1:0]                          irq,
  output logic [`ISADEC_NDMA-1:0]                          drq,
  input  wire logic                                        dec16,
  output logic                                             cdrom_en,
  input  wire logic [`ISADEC_NLD-1:0]                      cfg_act,
  input  wire logic [`ISADEC_NFN-1:0][`ISADEC_CFGW-1:0]    cfg_base,
  input  wire logic [`ISADEC_NLD-1:0][`ISADEC_IRQSELW-1:0] cfg_irq,
  input  wire logic [`ISADEC_NLD-1:0][`ISADEC_DMASELW-1:0] cfg_dma,
  input  wire logic [`ISADEC_NLD-1:0]                      dev_irq,
  input  wire logic [`ISADEC_NLD-1:0]                      dev_drq,
  output logic [`ISADEC_NFN-1:0]                           pio_sel,
  output logic [`ISADEC_NLD-1:0]                           dma_sel,
  output logic                                             rd_strobe,
  input  wire logic [`ISADEC_DW-1:0]                       rd_data,
  output logic                                             wr_pulse,
  output logic [`ISADEC_DW-1:0]                            wr_data
);
  isadec_pkg::isadec_regs_type r;
  isadec_pkg::isadec_regs_type next_r;
  logic [`ISADEC_NFN-1:0]      hit;
  logic                        ior_now;
  logic                        iow_now;
  logic                        aen_now;
  logic [`ISADEC_NDMA-1:0]     dack_now;
  logic                        dack_any;
  logic                        ior_fall;
  logic                        ior_rise;
  logic                        iow_fall;
  logic                        iow_rise;
  logic                        pio_ok;
  logic [`ISADEC_NLD-1:0][`ISADEC_IRQSELW-1:0] dma_code;

  // Logical device that owns each function
  function automatic int ld_of(input int fn);
    case (fn)
      `ISADEC_FN_CODEC, `ISADEC_FN_SYNTH, `ISADEC_FN_LEG: ld_of = `ISADEC_LD_AUDIO;
      `ISADEC_FN_GAME:  ld_of = `ISADEC_LD_GAME;
      `ISADEC_FN_CTRL:  ld_of = `ISADEC_LD_CTRL;
      `ISADEC_FN_MIDI:  ld_of = `ISADEC_LD_MIDI;
      default:          ld_of = `ISADEC_LD_CDROM;
    endcase
  endfunction

  // Window size of each function
  function automatic int span_of(input int fn);
    case (fn)
      `ISADEC_FN_CODEC: span_of = `ISADEC_SPAN_CODEC;
      `ISADEC_FN_SYNTH: span_of = `ISADEC_SPAN_SYNTH;
      `ISADEC_FN_LEG:   span_of = `ISADEC_SPAN_LEG;
      `ISADEC_FN_GAME:  span_of = `ISADEC_SPAN_GAME;
      `ISADEC_FN_CTRL:  span_of = `ISADEC_SPAN_CTRL;
      `ISADEC_FN_MIDI:  span_of = `ISADEC_SPAN_MIDI;
      default:          span_of = `ISADEC_SPAN_CDROM;
    endcase
  endfunction

  // Keep only the lowest set bit
  function automatic logic [`ISADEC_NFN-1:0] first_fn(input logic [`ISADEC_NFN-1:0] v);
    first_fn = v & (~v + `ISADEC_NFN'(1));
  endfunction

  // Active devices whose channel selector equals a given code
  function automatic logic [`ISADEC_NLD-1:0] chan_users(
    input logic [`ISADEC_NLD-1:0]                      act,
    input logic [`ISADEC_NLD-1:0][`ISADEC_IRQSELW-1:0] sel,
    input logic [`ISADEC_IRQSELW-1:0]                  code);
    for (int i = 0; i < `ISADEC_NLD; i++) begin
      chan_users[i] = act[i] && (sel[i] == code);
    end
  endfunction

  // One comparator per function
  genvar g;
  generate
    for (g = 0; g < `ISADEC_NFN; g++) begin : g_win
      // 12-bit for codec and control only
      isadec_match #(
        .SPAN  (span_of(g)),
        .USE12 (g == `ISADEC_FN_CODEC || g == `ISADEC_FN_CTRL)
      ) u_match (
        .addr  (r.sa_l),
        .base  (cfg_base[g]),
        // inactive devices never match; CDROM off with 16-bit decode
        .en    (cfg_act[ld_of(g)] && !(g == `ISADEC_FN_CDROM && dec16)),
        .dec16 (dec16),
        .hit   (hit[g])
      );
    end
  endgenerate

  // Agreed pin levels: a change counts once stages two and three agree
  always_comb begin
    ior_now  = (r.ior_s[1] == r.ior_s[2]) ? r.ior_s[2] : r.ior_l;
    iow_now  = (r.iow_s[1] == r.iow_s[2]) ? r.iow_s[2] : r.iow_l;
    aen_now  = (r.aen_s[1] == r.aen_s[2]) ? r.aen_s[2] : r.aen_l;
    dack_now = (r.dack_s[1] == r.dack_s[2]) ? r.dack_s[2] : r.dack_l;
  end

  // Channel selectors widened to the code width, one entry per device
  always_comb begin
    for (int i = 0; i < `ISADEC_NLD; i++) begin
      dma_code[i] = `ISADEC_IRQSELW'(cfg_dma[i]);
    end
  end

  // Strobe edges and cycle type
  assign ior_fall = r.ior_l && !ior_now;
  assign ior_rise = !r.ior_l && ior_now;
  assign iow_fall = r.iow_l && !iow_now;
  assign iow_rise = !r.iow_l && iow_now;
  assign dack_any = (dack_now != '1);
  assign pio_ok   = !aen_now && !dack_any && (hit != '0);

  // Next state of the whole port
  always_comb begin
    logic [`ISADEC_NLD-1:0] dma_dev;
    dma_dev = '0;
    next_r = r;
    // Three-stage input synchronisers
    next_r.ior_s  = {r.ior_s[1:0], ior_n};
    next_r.iow_s  = {r.iow_s[1:0], iow_n};
    next_r.aen_s  = {r.aen_s[1:0], aen};
    next_r.dack_s = {r.dack_s[1:0], dack_n};
    next_r.sa_s   = {r.sa_s[1:0], sa};
    next_r.d_s    = {r.d_s[1:0], data_in};
    next_r.ior_l  = ior_now;
    next_r.iow_l  = iow_now;
    next_r.aen_l  = aen_now;
    next_r.dack_l = dack_now;
    if (r.sa_s[1] == r.sa_s[2]) begin
      next_r.sa_l = r.sa_s[2];
    end
    if (r.d_s[1] == r.d_s[2]) begin
      next_r.d_l = r.d_s[2];
    end
    // acknowledged channel steers to its owner device
    for (int c = 0; c < `ISADEC_NDMA; c++) begin
      if (!dack_now[c]) begin
        dma_dev = dma_dev | chan_users(cfg_act, dma_code, `ISADEC_IRQSELW'(c + 1));
      end
    end
    dma_dev = dma_dev & (~dma_dev + `ISADEC_NLD'(1));
    // interrupt and request routing for active devices only
    for (int k = 0; k < `ISADEC_NIRQ; k++) begin
      next_r.irq[k] = |(dev_irq & chan_users(cfg_act, cfg_irq, `ISADEC_IRQSELW'(k + 1)));
    end
    for (int c = 0; c < `ISADEC_NDMA; c++) begin
      next_r.drq[c] = |(dev_drq & chan_users(cfg_act, dma_code, `ISADEC_IRQSELW'(c + 1)));
    end
    next_r.wr_pulse = 1'b0;
    case (r.st)
      isadec_pkg::ST_IDLE: begin
        next_r.fsel = '0;
        next_r.dsel = '0;
        next_r.oe_n = 1'b1;
        if (ior_fall || iow_fall) begin
          if (dack_any) begin
            // a channel no active device owns leaves the bus alone
            if (dma_dev != '0) begin
              next_r.dsel = dma_dev;
              next_r.st   = ior_fall ? isadec_pkg::ST_RD : isadec_pkg::ST_WR;
            end
          end else if (pio_ok) begin
            next_r.fsel = first_fn(hit);
            next_r.st   = ior_fall ? isadec_pkg::ST_RD : isadec_pkg::ST_WR;
          end
        end
      end
      isadec_pkg::ST_RD: begin
        next_r.dout = rd_data;
        next_r.oe_n = 1'b0;
        if (ior_rise) begin
          next_r.oe_n = 1'b1;
          next_r.st   = isadec_pkg::ST_IDLE;
        end
      end
      isadec_pkg::ST_WR: begin
        if (iow_rise) begin
          next_r.wr_pulse = 1'b1;
          next_r.wr_data  = r.d_l;
          next_r.st       = isadec_pkg::ST_IDLE;
        end
      end
      default: begin
        next_r.st = isadec_pkg::ST_IDLE;
      end
    endcase
  end

  // State register with synchronous reset
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      r          <= '0;
      r.st       <= isadec_pkg::ST_IDLE;
      r.ior_s    <= '1;
      r.iow_s    <= '1;
      r.aen_s    <= '1;
      r.dack_s   <= '1;
      r.ior_l    <= 1'b1;
      r.iow_l    <= 1'b1;
      r.aen_l    <= 1'b1;
      r.dack_l   <= '1;
      r.oe_n     <= 1'b1;
    end else begin
      r <= next_r;
    end
  end

  assign data_out  = r.dout;
  assign data_oe_n = r.oe_n;
  assign wr_data   = r.wr_data;
  assign wr_pulse  = r.wr_pulse;
  assign pio_sel   = r.fsel;
  assign dma_sel   = r.dsel;
  assign rd_strobe = (r.st == isadec_pkg::ST_RD);
  assign irq       = r.irq;
  assign drq       = r.drq;
  // CDROM pins free only without 16-bit decode
  assign cdrom_en  = !dec16;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);

  a_pio_needs_aen: assert property (
    $rose(|r.fsel) |-> $past(!r.aen_l) || $past(!aen_now))
    else $error("I/O select raised with AEN high");

  a_onehot_sel: assert property (
    $onehot0(r.fsel) && !((r.fsel != '0) && (r.dsel != '0)))
    else $error("More than one device select");

  a_read_drive: assert property (
    (r.st == isadec_pkg::ST_RD) ##1 (r.st == isadec_pkg::ST_RD) |-> !r.oe_n && r.dout == $past(rd_data))
    else $error("Read data not driven during read");

  a_idle_release: assert property (
    (r.st == isadec_pkg::ST_IDLE) ##1 (r.st == isadec_pkg::ST_IDLE) |-> r.oe_n)
    else $error("Data bus driven outside read");

  a_write_capture: assert property (
    r.wr_pulse |-> r.wr_data == $past(r.d_l) && $past(r.st) == isadec_pkg::ST_WR)
    else $error("Write data not taken at strobe rise");

  a_cdrom_off: assert property (
    dec16 && $rose(r.fsel[`ISADEC_FN_CDROM]) |-> 1'b0)
    else $error("CDROM selected under 16-bit decode");

  a_ten_bit_alias: assert property (
    $rose(r.fsel[`ISADEC_FN_GAME]) |-> $past(r.sa_l[`ISADEC_A12_MSB:`ISADEC_ALIAS_LSB]) == '0)
    else $error("10-bit function matched with A10 or A11 set");

  a_upper_zero: assert property (
    dec16 && $rose(|r.fsel) |-> $past(r.sa_l[`ISADEC_AW-1:`ISADEC_HI_LSB]) == '0)
    else $error("16-bit decode matched with upper bits set");

  a_inactive_quiet: assert property (
    $rose(r.fsel[`ISADEC_FN_MIDI]) |-> $past(cfg_act[`ISADEC_LD_MIDI]))
    else $error("Inactive device selected");

  a_dma_no_addr: assert property (
    $rose(|r.dsel) |-> r.fsel == '0 ##1 r.fsel == '0)
    else $error("Address decode during DMA acknowledge");

  a_dma_onehot: assert property (
    $onehot0(r.dsel))
    else $error("More than one DMA device select");

  a_drive_owned: assert property (
    !r.oe_n |-> (r.fsel != '0) || (r.dsel != '0))
    else $error("Data bus driven with no device selected");

  a_route_inactive: assert property (
    (cfg_act == '0) |=> (r.irq == '0) && (r.drq == '0))
    else $error("Request routed while no device is active");

  a_wr_single: assert property (
    r.wr_pulse |=> !r.wr_pulse)
    else $error("Write pulse longer than one cycle");
endmodule // isadec_top

// ===== bench/isadec_host.sv
// ISA host model running single byte I/O and DMA cycles
`timescale 1ns/10ps
`include "isadec_params.svh"
module isadec_host (
  input  wire logic                  clk,
  output logic [`ISADEC_AW-1:0]      sa,
  output logic                       aen,
  output logic                       ior_n,
  output logic                       iow_n,
  output logic [`ISADEC_NDMA-1:0]    dack_n,
  output logic [`ISADEC_DW-1:0]      data_in,
  input  wire logic [`ISADEC_DW-1:0] data_out,
  input  wire logic                  data_oe_n
);
  // Idle bus at time zero
  initial begin
    sa = 16'h0000;
    aen = 1'b1;
    ior_n = 1'b1;
    iow_n = 1'b1;
    dack_n = 3'h7;
    data_in = 8'h00;
  end

  // One cycle: setup, strobe, hold, release, gap
  task automatic xfer(input logic [15:0] a, input logic dma, input logic [2:0] dk,
                      input logic wr, input logic [7:0] wd, output logic [7:0] rd);
    @(negedge clk);
    sa = a;
    aen = dma;
    dack_n = dk;
    if (wr) data_in = wd;
    repeat (2) @(negedge clk);
    if (wr) iow_n = 1'b0;
    else ior_n = 1'b0;
    repeat (10) @(negedge clk);
    rd = data_out;
    iow_n = 1'b1;
    ior_n = 1'b1;
    repeat (6) @(negedge clk);
    // Released address and data lines show the inverse of their last value; AEN and DACK return to idle
    sa = ~sa;
    data_in = ~data_in;
    aen = 1'b1;
    dack_n = 3'h7;
    repeat (18) @(negedge clk);
  endtask
endmodule // isadec_host

// ===== bench/isa_io_decode_logical_devices_bench.sv
// Self-checking bench for the ISA slave port and decoder
`timescale 1ns/10ps
`include "isadec_params.svh"
module isa_io_decode_logical_devices_bench;
  logic              clk, sys_rst, aen, ior_n, iow_n, dec16, cdrom_en;
  logic              data_oe_n, rd_strobe, wr_pulse, oe_acc, rd_acc;
  logic [15:0]       sa;
  logic [7:0]        data_in, data_out, rd_data, wr_data, wd_seen;
  logic [2:0]        dack_n, drq;
  logic [5:0]        irq;
  logic [4:0]        cfg_act, dev_irq, dev_drq, dma_sel, dsel_acc;
  logic [6:0]        pio_sel, sel_acc;
  logic [6:0][11:0]  cfg_base;
  logic [4:0][2:0]   cfg_irq;
  logic [4:0][1:0]   cfg_dma;
  logic [31:0]       seed, r;
  int                fails, checked, wp_cnt;
  // Window sizes and owning device of each function
  int                span[7] = '{3, 2, 4, 0, 3, 1, 3};
  int                ldof[7] = '{0, 0, 0, 1, 2, 3, 4};

  isadec_top uut (.clk(clk), .sys_rst(sys_rst), .sa(sa), .aen(aen), .ior_n(ior_n),
    .iow_n(iow_n), .dack_n(dack_n), .data_in(data_in), .data_out(data_out),
    .data_oe_n(data_oe_n), .irq(irq), .drq(drq), .dec16(dec16), .cdrom_en(cdrom_en),
    .cfg_act(cfg_act), .cfg_base(cfg_base), .cfg_irq(cfg_irq), .cfg_dma(cfg_dma),
    .dev_irq(dev_irq), .dev_drq(dev_drq), .pio_sel(pio_sel), .dma_sel(dma_sel),
    .rd_strobe(rd_strobe), .rd_data(rd_data), .wr_pulse(wr_pulse), .wr_data(wr_data));
  isadec_host host (.clk(clk), .sa(sa), .aen(aen), .ior_n(ior_n), .iow_n(iow_n),
    .dack_n(dack_n), .data_in(data_in), .data_out(data_out), .data_oe_n(data_oe_n));

  // 200 MHz clock
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // Gather what the port shows during one bus cycle
  always @(negedge clk) begin
    sel_acc <= sel_acc | pio_sel;
    dsel_acc <= dsel_acc | dma_sel;
    oe_acc <= oe_acc & data_oe_n;
    rd_acc <= rd_acc | rd_strobe;
    if (wr_pulse === 1'b1) begin
      wp_cnt <= wp_cnt + 1;
      wd_seen <= wr_data;
    end
  end

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // Reference decode: lowest hitting function wins
  function automatic logic [6:0] exp_sel(input logic [15:0] a, input logic d16);
    int x;
    int msb;
    exp_sel = '0;
    for (int f = 0; f < 7; f++) begin
      msb = (f == 0 || f == 4) ? 11 : 9;
      x = int'(a[11:0] ^ cfg_base[f]) >> span[f];
      x = x & ((1 << (msb + 1 - span[f])) - 1);
      if (cfg_act[ldof[f]] && !(f == 6 && d16) && !(d16 && a[15:12] != 4'h0)
          && !(msb == 9 && a[11:10] != 2'h0) && x == 0 && exp_sel == '0)
        exp_sel[f] = 1'b1;
    end
  endfunction

  // Reference sideband mapping as {drq, irq}
  function automatic logic [8:0] exp_side();
    exp_side = '0;
    for (int d = 0; d < 5; d++) begin
      if (cfg_act[d] && cfg_irq[d] != 3'h0 && dev_irq[d]) exp_side[int'(cfg_irq[d]) - 1] = 1'b1;
      if (cfg_act[d] && cfg_dma[d] != 2'h0 && dev_drq[d]) exp_side[int'(cfg_dma[d]) + 5] = 1'b1;
    end
  endfunction

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      fails++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic clear_acc();
    @(posedge clk);
    sel_acc = '0;
    dsel_acc = '0;
    oe_acc = 1'b1;
    rd_acc = 1'b0;
    wp_cnt = 0;
  endtask

  // One programmed I/O byte with all checks
  task automatic pio(input logic [15:0] a, input logic ae, input logic wr);
    logic [6:0] es;
    logic [7:0] rv;
    logic [31:0] q;
    es = ae ? 7'h00 : exp_sel(a, dec16);
    q = rnd();
    @(negedge clk);
    rd_data = q[15:8];
    clear_acc();
    host.xfer(a, ae, 3'h7, wr, q[7:0], rv);
    chk("pio_sel", sel_acc, es);
    chk("dma_sel", dsel_acc, 0);
    chk("wr_pulses", wp_cnt, wr && es != 0);
    if (wr && es != 0) chk("wr_data", wd_seen, q[7:0]);
    chk("oe_idle", oe_acc, !(es != 0 && !wr));
    if (!wr && es != 0) chk("rd_byte", rv, q[15:8]);
    chk("oe_after", data_oe_n, 1);
    chk("rd_strobe", rd_acc, !wr && es != 0);
  endtask

  // One DMA byte on the channels low in dk
  task automatic dma(input logic [2:0] dk, input logic wr);
    logic [7:0] rv;
    logic [4:0] ed;
    ed = '0;
    for (int d = 0; d < 5; d++)
      if (cfg_act[d] && cfg_dma[d] != 2'h0 && !dk[int'(cfg_dma[d]) - 1] && ed == '0) ed[d] = 1'b1;
    r = rnd();
    clear_acc();
    host.xfer(r[15:0], 1'b1, dk, wr, r[23:16], rv);
    chk("dma_sel", dsel_acc, ed);
    chk("pio_sel", sel_acc, 0);
    chk("dma_oe", oe_acc, !(ed != 0 && !wr));
    chk("dma_rd_strobe", rd_acc, ed != 0 && !wr);
    chk("dma_wr_pulses", wp_cnt, ed != 0 && wr);
    if (wr && ed != 0) chk("dma_wr_data", wd_seen, r[23:16]);
    if (!wr && ed != 0) chk("dma_rd_byte", rv, rd_data);
  endtask

  task automatic give_verdict();
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  // Watchdog for a hung run
  initial begin
    #150000;
    fails++;
    give_verdict();
  end

  // Main sequence
  initial begin
    seed = 32'hde0c;
    fails = 0;
    checked = 0;
    sys_rst = 1'b1;
    dec16 = 1'b0;
    cfg_act = 5'h00;
    cfg_base = {12'h1e8, 12'h330, 12'h4a0, 12'h201, 12'h220, 12'h388, 12'hc30};
    cfg_irq = {3'd5, 3'd6, 3'd0, 3'd3, 3'd1};
    cfg_dma = {2'd2, 2'd3, 2'd0, 2'd0, 2'd1};
    dev_irq = 5'h00;
    dev_drq = 5'h00;
    rd_data = 8'h00;
    repeat (6) @(negedge clk);
    sys_rst = 1'b0;
    @(negedge clk);
    chk("oe_rst", data_oe_n, 1);
    chk("sel_rst", {pio_sel, dma_sel, wr_pulse, irq, drq}, 0);
    pio({4'h0, cfg_base[0]}, 1'b0, 1'b0);
    $display("test reset done");
    for (int i = 0; i < 80; i++) begin
      r = rnd();
      cfg_act = (i < 40) ? 5'h1f : r[28:24];
      dec16 = r[20] & r[21];
      pio({r[7] ? r[11:8] : 4'h0, (cfg_base[r[2:0] % 7] | (12'(r[19:16]) &
          ((12'h1 << span[r[2:0] % 7]) - 12'h1))) ^ {r[15:14] & {2{r[13]}}, 10'h0}},
          r[22] & r[23], r[12]);
      chk("cdrom_en", cdrom_en, !dec16);
    end
    $display("test decode done");
    cfg_act = 5'h1f;
    dec16 = 1'b0;
    for (int c = 0; c < 3; c++) dma(~(3'h1 << c), c[0]);
    cfg_act = 5'h1e;
    dma(3'h6, 1'b0);
    $display("test dma done");
    for (int i = 0; i < 8; i++) begin
      r = rnd();
      cfg_act = r[14:10];
      dev_irq = r[4:0];
      dev_drq = r[9:5];
      repeat (3) @(negedge clk);
      chk("irq_drq", {drq, irq}, exp_side());
    end
    $display("test sideband done");
    give_verdict();
  end
endmodule // isa_io_decode_logical_devices_bench
